// ===== pss_chk.sv
// assertion checker for the sram port
`timescale 1ns/10ps
module pss_chk #(
	parameter int LANES = 4
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic suspend_gate_n,
	input wire pss_pkg::pss_ctrl_s ctrl,
	input wire logic sleep_request,
	input wire logic output_enable_n,
	input wire logic [LANES*8-1:0] data_out,
	input wire logic data_oe,
	input wire logic sleeping
);
	import pss_pkg::*;
	wire logic sel = !ctrl.chip_select_one_n && ctrl.chip_select_two && !ctrl.chip_select_three_n;
	wire logic go = suspend_gate_n && !sleeping;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	AST_OE_OFF: assert property (output_enable_n |-> !data_oe) else $error("oe drives");
	AST_FREEZE: assert property (!suspend_gate_n |=> $stable(data_out)) else $error("moved");
	AST_RD: assert property (sel && ctrl.write_n && !ctrl.advance_load && go && !sleeping
		##1 go [*2] |=> data_oe || output_enable_n) else $error("read not driven");
	AST_WR: assert property (sel && !ctrl.write_n && !ctrl.advance_load && go
		##1 go [*2] |=> !data_oe) else $error("write data phase driven");
	AST_DESEL: assert property (!sel && !ctrl.advance_load && go
		##1 go [*2] |=> !data_oe) else $error("deselect driven");
	AST_SLEEP: assert property (sleep_request && suspend_gate_n |=> sleeping) else $error("sl");
	AST_WAKE: assert property (!sleep_request && suspend_gate_n |=> !sleeping) else $error("wk");
	AST_RST: assert property (disable iff (1'b0) reset |=> data_out == '0 && !data_oe)
		else $error("reset state");
endmodule : pss_chk
bind pss_sram_port pss_chk #(.LANES(LANES)) i_pss_chk (.clk(clk), .reset(reset),
	.suspend_gate_n(suspend_gate_n), .ctrl(ctrl), .sleep_request(sleep_request),
	.output_enable_n(output_enable_n), .data_out(data_out), .data_oe(data_oe), .sleeping(sleeping));

// ===== pss_host.sv
// host side model that presents write data
`timescale 1ns/10ps
module pss_host (
	input wire logic clk,
	input wire logic suspend_gate_n,
	input wire logic wr,
	input wire logic [35:0] wd,
	output logic [31:0] data_in,
	output logic [3:0] parity_lane_in
);
	logic wr_reg = 1'b0;
	logic [35:0] wd_reg = 36'h0;
	logic wr2_reg = 1'b0;
	logic [35:0] wd2_reg = 36'h0;
	initial {parity_lane_in, data_in} = 36'h0;
	// stalled cycles hold everything; undriven bus toggles
	always @(posedge clk) begin
		if (suspend_gate_n) begin
			wr_reg <= wr;
			wd_reg <= wd;
			wr2_reg <= wr_reg;
			wd2_reg <= wd_reg;
			// data stands in the cycle before the edge at which the port writes the word
			{parity_lane_in, data_in} <= wr2_reg ? wd2_reg : ~{parity_lane_in, data_in};
		end
	end
endmodule : pss_host

// ===== pss_pkg.sv
// package for the pipelined synchronous sram port
package pss_pkg;
	localparam int PSS_LANE_BITS = 9;
	localparam int PSS_LANES_WIDE = 4;
	localparam int PSS_LANES_NARROW = 2;
	localparam int PSS_ADDR_WIDE = 19;
	localparam int PSS_ADDR_NARROW = 20;
	localparam int PSS_BURST_BITS = 2;
	localparam logic PSS_ORDER_INTERLEAVED = 1'b0;
	localparam logic PSS_ORDER_LINEAR = 1'b1;
	localparam logic [1:0] PSS_BURST_LAST = 2'h3;
	localparam int PSS_PIPE_DEPTH = 2;

	typedef enum logic [2:0] {
		PSS_IDLE = 3'b001,
		PSS_READ = 3'b010,
		PSS_WRITE = 3'b100
	} pss_op_e;

	typedef struct packed {
		logic chip_select_one_n;
		logic chip_select_two;
		logic chip_select_three_n;
		logic write_n;
		logic advance_load;
	} pss_ctrl_s;
endpackage : pss_pkg

// ===== pss_sram_port.sv
// pipelined synchronous burst sram core with two-stage read and write pipeline
`timescale 1ns/10ps
// Operation
// - inputs captured on rising clock edge only
// - read data launched from output registers
// - suspend gate low freezes all state except the sleep register
// - new read or write every cycle
// - write only with strobe, lanes select bytes
// - writes complete self-timed, no pulse timing
// - selected only when all three selects active
// - drivers off during write data phase
// - 512Kx36 or 1Mx18 organisation
// - burst order linear or interleaved
// - sleep request input, data retained
// - output enable gates drivers asynchronously
// - lane select gates its byte and parity
module pss_sram_port #(
	parameter int LANES = pss_pkg::PSS_LANES_WIDE,
	parameter int ADDR_BITS = pss_pkg::PSS_ADDR_WIDE,
	parameter int DEPTH = 2 ** ADDR_BITS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic suspend_gate_n,
	input wire pss_pkg::pss_ctrl_s ctrl,
	input wire logic [ADDR_BITS-1:0] address,
	input wire logic [LANES-1:0] byte_lane_write_n,
	input wire logic burst_order_linear,
	input wire logic sleep_request,
	input wire logic output_enable_n,
	input wire logic [LANES*8-1:0] data_in,
	input wire logic [LANES-1:0] parity_lane_in,
	output logic [LANES*8-1:0] data_out,
	output logic [LANES-1:0] parity_lane_out,
	output logic data_oe,
	output logic sleeping
);
	import pss_pkg::*;

	localparam int WORD = LANES * PSS_LANE_BITS;

	// each lane stores byte in low eight bits and parity in bit eight
	logic [WORD-1:0] array_mem [DEPTH];

	pss_ctrl_s ctrl_reg;
	logic [ADDR_BITS-1:0] addr_in_reg;
	logic [LANES-1:0] lanes_in_reg;
	logic order_reg;
	logic sleep_reg;

	logic [ADDR_BITS-1:0] base_reg;
	logic [1:0] burst_reg;
	logic [1:0] burst_next;
	logic burst_write_reg;
	logic burst_live_reg;

	pss_op_e op1_reg;
	logic [ADDR_BITS-1:0] addr1_reg;
	logic [LANES-1:0] lanes1_reg;
	pss_op_e op2_reg;
	logic [ADDR_BITS-1:0] addr2_reg;
	logic [LANES-1:0] lanes2_reg;

	logic [WORD-1:0] read_word_reg;
	logic drive_reg;

	logic run;
	logic selected;
	pss_op_e op_now;
	logic [ADDR_BITS-1:0] addr_now;
	logic [LANES-1:0] lanes_now;
	logic [WORD-1:0] write_word;
	logic [WORD-1:0] merged;

	function automatic logic [1:0] pss_burst_step(input logic [1:0] start, input logic [1:0] cnt,
		input logic linear);
		logic [1:0] next_cnt;
		next_cnt = cnt + 2'h1;
		if (linear == PSS_ORDER_LINEAR) begin
			pss_burst_step = start + next_cnt;
		end else begin
			pss_burst_step = start ^ next_cnt;
		end
	endfunction : pss_burst_step

	// the suspend gate, sleep and reset qualify the burst, pipeline, array write and output updates
	assign run = suspend_gate_n && !sleep_reg;

	// input registers, captured on rising edge while enabled
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_reg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
			addr_in_reg <= '0;
			lanes_in_reg <= '1;
			order_reg <= PSS_ORDER_INTERLEAVED;
		end else if (suspend_gate_n) begin
			ctrl_reg <= ctrl;
			addr_in_reg <= address;
			lanes_in_reg <= byte_lane_write_n;
			order_reg <= burst_order_linear;
		end
	end

	// sleep request sampled each edge; array contents are never cleared
	always_ff @(posedge clk) begin
		if (reset) begin
			sleep_reg <= 1'b0;
		end else begin
			sleep_reg <= sleep_request;
		end
	end

	assign selected = !ctrl_reg.chip_select_one_n && ctrl_reg.chip_select_two
		&& !ctrl_reg.chip_select_three_n;

	// burst count offset: counts 0..3 from the loaded low bits
	always_comb begin
		burst_next = pss_burst_step(base_reg[PSS_BURST_BITS-1:0], burst_reg, order_reg);
	end

	// decode the current cycle: load a new access or continue a burst
	always_comb begin
		op_now = PSS_IDLE;
		addr_now = addr_in_reg;
		lanes_now = lanes_in_reg;
		if (ctrl_reg.advance_load) begin
			if (burst_live_reg) begin
				op_now = burst_write_reg ? PSS_WRITE : PSS_READ;
				// upper bits held, low two advance and wrap
				addr_now = {base_reg[ADDR_BITS-1:PSS_BURST_BITS], burst_next};
			end
		end else if (selected) begin
			op_now = ctrl_reg.write_n ? PSS_READ : PSS_WRITE;
		end
	end

	// burst tracking
	always_ff @(posedge clk) begin
		if (reset) begin
			base_reg <= '0;
			burst_reg <= '0;
			burst_write_reg <= 1'b0;
			burst_live_reg <= 1'b0;
		end else if (run) begin
			if (!ctrl_reg.advance_load) begin
				base_reg <= addr_in_reg;
				burst_reg <= '0;
				burst_write_reg <= !ctrl_reg.write_n;
				burst_live_reg <= selected;
			end else if (burst_live_reg) begin
				burst_reg <= burst_reg + 2'h1;
			end
		end
	end

	// two-stage pipeline: write data arrives three cycles after its address
	always_ff @(posedge clk) begin
		if (reset) begin
			op1_reg <= PSS_IDLE;
			addr1_reg <= '0;
			lanes1_reg <= '1;
			op2_reg <= PSS_IDLE;
			addr2_reg <= '0;
			lanes2_reg <= '1;
		end else if (run) begin
			op1_reg <= op_now;
			addr1_reg <= addr_now;
			lanes1_reg <= lanes_now;
			op2_reg <= op1_reg;
			addr2_reg <= addr1_reg;
			lanes2_reg <= lanes1_reg;
		end
	end

	// write data packed per lane as parity over byte
	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++) begin : g_lane
			assign write_word[gl*PSS_LANE_BITS +: PSS_LANE_BITS] =
				{parity_lane_in[gl], data_in[gl*8 +: 8]};
			// only enabled lanes replace their byte and parity
			assign merged[gl*PSS_LANE_BITS +: PSS_LANE_BITS] = !lanes2_reg[gl] ?
				write_word[gl*PSS_LANE_BITS +: PSS_LANE_BITS] :
				array_mem[addr2_reg][gl*PSS_LANE_BITS +: PSS_LANE_BITS];
			assign data_out[gl*8 +: 8] = read_word_reg[gl*PSS_LANE_BITS +: 8];
			assign parity_lane_out[gl] = read_word_reg[gl*PSS_LANE_BITS + 8];
		end
	endgenerate

	// self-timed array write on the clock, data sampled at the data phase edge
	always_ff @(posedge clk) begin
		if (run && !reset && op2_reg == PSS_WRITE) begin
			array_mem[addr2_reg] <= merged;
		end
	end

	// output register: read word launched one stage after lookup
	always_ff @(posedge clk) begin
		if (reset) begin
			read_word_reg <= '0;
			drive_reg <= 1'b0;
		end else if (run) begin
			// forward a write completing this edge to a read of the same word
			if (op1_reg == PSS_READ && op2_reg == PSS_WRITE && addr1_reg == addr2_reg) begin
				read_word_reg <= merged;
			end else begin
				read_word_reg <= array_mem[addr1_reg];
			end
			drive_reg <= (op1_reg == PSS_READ);
		end
	end

	// drivers off during write data phase, idle, or whenever oe is high
	assign data_oe = drive_reg && !output_enable_n;
	assign sleeping = sleep_reg;

	initial begin
		if (!((LANES == PSS_LANES_WIDE && ADDR_BITS == PSS_ADDR_WIDE)
			|| (LANES == PSS_LANES_NARROW && ADDR_BITS == PSS_ADDR_NARROW))) begin
			$error("unsupported organisation");
		end
	end
endmodule : pss_sram_port

// ===== tb.sv
// testbench for the sram port
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
	import pss_pkg::*;
	typedef struct {logic [1:0] op; logic [18:0] a; logic [3:0] l; logic [35:0] d;} pss_row_s;
	logic clk = 0, reset = 1, suspend_gate_n = 1, sleep_request = 0, output_enable_n = 0;
	logic wr = 0, data_oe, sleeping, burst_order = 0;
	logic [18:0] address = 19'h0;
	logic [3:0] byte_lane_write_n = 4'hf, parity_lane_in, parity_lane_out;
	logic [31:0] data_in, data_out;
	logic [35:0] wd = 36'h0;
	logic [35:0] mem [int];
	logic [37:0] exp_q [$];
	int failures = 0, samples_checked = 0;
	pss_ctrl_s ctrl = 5'h1a;
	pss_ctrl_s ops [4] = '{5'h0a, 5'h08, 5'h1a, 5'h04};
	pss_row_s rows [15] = '{'{2'h1, 19'h10, 4'h0, 36'h123456789},
		'{2'h1, 19'h7ffff, 4'h0, 36'hfedcba987}, '{2'h0, 19'h10, 4'hf, 36'h0},
		'{2'h1, 19'h10, 4'h5, 36'habcdef012}, '{2'h0, 19'h10, 4'hf, 36'h0},
		'{2'h3, 19'h10, 4'h0, 36'h0}, '{2'h2, 19'h10, 4'h0, 36'h0}, '{2'h0, 19'h10, 4'hf, 36'h0},
		'{2'h0, 19'h7ffff, 4'hf, 36'h0}, '{2'h1, 19'h10, 4'hf, 36'h0}, '{2'h0, 19'h10, 4'hf, 36'h0},
		'{2'h1, 19'h20, 4'h0, 36'h111111111}, '{2'h1, 19'h21, 4'h0, 36'h222222222},
		'{2'h1, 19'h22, 4'h0, 36'h333333333}, '{2'h1, 19'h23, 4'h0, 36'h444444444}};
	always #2 clk = ~clk;
	pss_sram_port i_pss_sram_port (.clk(clk), .reset(reset), .suspend_gate_n(suspend_gate_n),
		.ctrl(ctrl), .address(address), .byte_lane_write_n(byte_lane_write_n),
		.burst_order_linear(burst_order), .sleep_request(sleep_request),
		.output_enable_n(output_enable_n),
		.data_in(data_in), .parity_lane_in(parity_lane_in), .data_out(data_out),
		.parity_lane_out(parity_lane_out), .data_oe(data_oe), .sleeping(sleeping));
	pss_host i_pss_host (.clk(clk), .suspend_gate_n(suspend_gate_n), .wr(wr), .wd(wd),
		.data_in(data_in), .parity_lane_in(parity_lane_in));
	// one op per cycle; the result of the op three issues back is checked first
	task automatic issue(input logic [1:0] op, input logic [18:0] a, input logic [3:0] l,
		input logic [35:0] d);
		logic [37:0] e;
		@(negedge clk);
		if (exp_q.size() == 3) begin
			e = exp_q.pop_front();
			`CHK("oe", e[37:36] == 2'h0, data_oe)
			if (e[37:36] == 2'h0) `CHK("rd", e[35:0], {parity_lane_out, data_out})
		end
		ctrl = ops[op];
		address = a;
		byte_lane_write_n = l;
		wr = op == 2'h1;
		wd = d;
		for (int j = 0; j < 4; j++) begin
			if (op == 2'h1 && !l[j]) mem[a] = {j == 3 ? d[35] : mem[a][35], mem[a][34:0]};
			if (op == 2'h1 && !l[j]) mem[a][32+j] = d[32+j];
			if (op == 2'h1 && !l[j]) mem[a][8*j +: 8] = d[8*j +: 8];
		end
		exp_q.push_back({op, mem[a]});
	endtask : issue
	// load a read, continue three times, then deselect; offsets follow the chosen order
	task automatic burst(input logic lin, input logic [18:0] a);
		logic [1:0] o;
		@(negedge clk);
		burst_order = lin;
		ctrl = ops[0];
		address = a;
		wr = 0;
		for (int i = 1; i < 7; i++) begin
			@(negedge clk);
			ctrl = i < 4 ? 5'h1b : 5'h1a;
			if (i >= 3) begin
				o = lin ? a[1:0] + 2'(i - 3) : a[1:0] ^ 2'(i - 3);
				`CHK("burst oe", 1'b1, data_oe)
				`CHK("burst", mem[{a[18:2], o}], {parity_lane_out, data_out})
			end
		end
	endtask : burst
	task automatic report_and_stop;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		#2000;
		failures++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(negedge clk);
		reset = 0;
		`CHK("rst", 1'b0, data_oe | sleeping | (|data_out))
		foreach (rows[i]) issue(rows[i].op, rows[i].a, rows[i].l, rows[i].d);
		repeat (3) issue(2'h2, 19'h10, 4'hf, 36'h0);
		$display("rows done");
		issue(2'h0, 19'h7ffff, 4'hf, 36'h0);
		@(negedge clk);
		suspend_gate_n = 0;
		ctrl = 5'h1a;
		repeat (3) @(negedge clk);
		issue(2'h2, 19'h10, 4'hf, 36'h0);
		suspend_gate_n = 1;
		repeat (3) issue(2'h2, 19'h10, 4'hf, 36'h0);
		$display("suspend done");
		burst(1'b0, 19'h21);
		burst(1'b1, 19'h21);
		$display("burst done");
		exp_q.delete();
		issue(2'h0, 19'h10, 4'hf, 36'h0);
		repeat (2) issue(2'h2, 19'h10, 4'hf, 36'h0);
		@(negedge clk);
		output_enable_n = 1;
		#0.5;
		`CHK("oe off", 1'b0, data_oe)
		output_enable_n = 0;
		#0.5;
		`CHK("oe on", 1'b1, data_oe)
		$display("output enable done");
		sleep_request = 1;
		output_enable_n = 1;
		repeat (2) @(negedge clk);
		`CHK("sleep", 1'b1, sleeping)
		sleep_request = 0;
		repeat (2) @(negedge clk);
		`CHK("wake", 1'b0, sleeping)
		$display("sleep done");
		report_and_stop;
	end
endmodule : tb
